// ===== verilog/ram_params.svh
// constants for the embedded dual-port ram block
`ifndef RAM_PARAMS_SVH
`define RAM_PARAMS_SVH

// array geometry defaults (mid-size block, 512 x 16)
`define RAM_ADDR_W      9
`define RAM_DATA_W      16

// register bus geometry
`define AXI_ADDR_W      4
`define AXI_DATA_W      32

// register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_CONFIG      4'h8

// ctrl fields: read-enable gates per port
`define CTRL_W          2
`define CTRL_RST        2'h0

// status fields: sticky, write one to clear
`define STAT_W          2
`define STAT_WCONF      0
`define STAT_UNDEF      1
`define STAT_RST        2'h0

// config word padding above the packed fields
`define CFG_PAD_W       23

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== verilog/ram_pkg.sv
// types for the embedded dual-port ram block
package ram_pkg;

  // how the port enables map onto the register groups
  typedef enum logic [1:0] {CLK_SINGLE, CLK_RW, CLK_IO} clk_mode_t;

  // read-during-write output choice
  typedef enum logic [1:0] {RDW_NEW, RDW_OLD, RDW_DC} rdw_t;

  // physical flavour of the block
  typedef enum logic [1:0] {KIND_MID, KIND_LARGE, KIND_LOGIC} kind_t;

endpackage

// ===== verilog/ram_store.sv
// flip-flop storage array with two write ports and two read ports
`timescale 1ns/10ps
`default_nettype none
`include "ram_params.svh"

module ram_store #(
  parameter int              AW        = `RAM_ADDR_W,
  parameter int              DW        = `RAM_DATA_W,
  parameter logic [DW-1:0]   INIT_WORD = '0
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          we_a,
  input  wire logic [AW-1:0] waddr_a,
  input  wire logic [DW-1:0] wdata_a,
  input  wire logic          we_b,
  input  wire logic [AW-1:0] waddr_b,
  input  wire logic [DW-1:0] wdata_b,
  input  wire logic [AW-1:0] raddr_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [DW-1:0] rdata_a,
  output logic      [DW-1:0] rdata_b
);

  localparam int DEPTH = 1 << AW;

  logic [DW-1:0] mem_q [DEPTH];

  // one cell per entry; reset loads the fill word, port a wins a clash
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_cell
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        mem_q[i] <= INIT_WORD;
      else if (we_a && waddr_a == AW'(i))
        mem_q[i] <= wdata_a;
      else if (we_b && waddr_b == AW'(i))
        mem_q[i] <= wdata_b;
    end
  end

  // reads show the contents before this edge's write
  assign rdata_a = mem_q[raddr_a];
  assign rdata_b = mem_q[raddr_b];

endmodule
`default_nettype wire

// ===== verilog/axil_regs.sv
// axi4-lite slave holding control, sticky status and config words
`timescale 1ns/10ps
`default_nettype none
`include "ram_params.svh"

module axil_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [`AXI_DATA_W-1:0]      rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [`STAT_W-1:0]     stat_set,
  input  wire logic [`AXI_DATA_W-1:0] cfg_word,
  output logic [`CTRL_W-1:0]          ctrl_q
);

  logic                   aw_hold_q;
  logic [`AXI_ADDR_W-1:0] aw_addr_q;
  logic                   w_hold_q;
  logic [`AXI_DATA_W-1:0] w_data_q;
  logic                   w_strb0_q;
  logic [`STAT_W-1:0]     stat_q;
  logic [`STAT_W-1:0]     stat_clr;
  logic [`AXI_ADDR_W-1:0] wr_addr;
  logic [`AXI_DATA_W-1:0] wr_data;
  logic                   wr_lane0;
  logic                   do_write;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [`AXI_DATA_W-1:0] rd_mux;

  // address and data are taken in either order, then answered together
  assign awready  = !aw_hold_q && !bvalid;
  assign wready   = !w_hold_q && !bvalid;
  assign arready  = !rvalid;
  assign wr_addr  = aw_hold_q ? aw_addr_q : awaddr;
  assign wr_data  = w_hold_q ? w_data_q : wdata;
  assign wr_lane0 = w_hold_q ? w_strb0_q : wstrb[0];
  assign do_write = (aw_hold_q || awvalid) && (w_hold_q || wvalid)
                    && !bvalid;
  assign wr_hit   = wr_addr == `REG_CTRL || wr_addr == `REG_STATUS
                    || wr_addr == `REG_CONFIG;
  assign rd_hit   = araddr == `REG_CTRL || araddr == `REG_STATUS
                    || araddr == `REG_CONFIG;
  assign stat_clr = (do_write && wr_lane0 && wr_addr == `REG_STATUS)
                    ? wr_data[`STAT_W-1:0] : `STAT_RST;
  assign rd_mux   = araddr == `REG_CTRL   ? {{(`AXI_DATA_W-`CTRL_W){1'b0}},
                                             ctrl_q} :
                    araddr == `REG_STATUS ? {{(`AXI_DATA_W-`STAT_W){1'b0}},
                                             stat_q} :
                    araddr == `REG_CONFIG ? cfg_word : '0;

  // write address and data holding
  always_ff @(posedge aclk)
  begin
    if (!aresetn || do_write)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
        aw_hold_q <= 1'b1;
      if (wvalid && wready)
        w_hold_q <= 1'b1;
    end
  end

  // captured payloads, no reset needed
  always_ff @(posedge aclk)
  begin
    if (awvalid && awready)
      aw_addr_q <= awaddr;
    if (wvalid && wready)
    begin
      w_data_q  <= wdata;
      w_strb0_q <= wstrb[0];
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // control word and sticky status, a set beats a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `CTRL_RST;
      stat_q <= `STAT_RST;
    end
    else
    begin
      if (do_write && wr_lane0 && wr_addr == `REG_CTRL)
        ctrl_q <= wr_data[`CTRL_W-1:0];
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== verilog/dp_ram_top.sv
// dual-port ram block with selectable clocking and read-during-write
//
// Behaviour
// - split mode: write enable registers port a inputs, read enable port b inputs and outputs
// - each domain enable gates only its registers
// - output clear touches only output latch and register
// - split mode same-address read/write gives undefined data
// - single mode: one enable drives every register
// - same-port new data shows written word
// - same-port old data shows prior stored word
// - same-port don't-care output is unspecified
// - mixed-port choice: old, new or don't-care
// - mixed-port old data shows prior stored word
// - mixed-port new data shows written word next edge
// - mixed-port don't-care output is undefined
// - different clocks: mixed collision output undefined
// - large blocks power up with zero outputs
// - logic-array ram unregistered shows contents at power-up
// - cells start at fill word, output latch and output register still cleared
// - logic-array ram keeps only data registers inside
// - io mode: input enable all inputs, output enable outputs
// - output register adds one cycle of read latency
`timescale 1ns/10ps
`default_nettype none
`include "ram_params.svh"

module dp_ram_top
  import ram_pkg::*;
#(
  parameter int              AW        = `RAM_ADDR_W,
  parameter int              DW        = `RAM_DATA_W,
  parameter clk_mode_t       CLK_MODE  = CLK_SINGLE,
  parameter rdw_t            SAME_RDW  = RDW_NEW,
  parameter rdw_t            MIXED_RDW = RDW_OLD,
  parameter kind_t           KIND      = KIND_MID,
  parameter bit              OUT_REG   = 1'b0,
  parameter logic [DW-1:0]   INIT_WORD = '0
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce_a,
  input  wire logic                   we_a,
  input  wire logic                   re_a,
  input  wire logic [AW-1:0]          addr_a,
  input  wire logic [DW-1:0]          din_a,
  output logic      [DW-1:0]          q_a,
  output logic                        q_undef_a,
  input  wire logic                   ce_b,
  input  wire logic                   we_b,
  input  wire logic                   re_b,
  input  wire logic [AW-1:0]          addr_b,
  input  wire logic [DW-1:0]          din_b,
  output logic      [DW-1:0]          q_b,
  output logic                        q_undef_b,
  input  wire logic                   out_clr,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [`AXI_DATA_W-1:0]      rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready
);

  // static build choices, never changed while running
  localparam bit   IS_RW   = CLK_MODE == CLK_RW;
  localparam bit   IS_IO   = CLK_MODE == CLK_IO;
  localparam rdw_t SP_MODE = KIND == KIND_LOGIC ? RDW_DC : SAME_RDW;

  logic [AW-1:0]     addr_in  [2];
  logic [DW-1:0]     din_in   [2];
  logic [1:0]        we_in;
  logic [1:0]        re_in;
  logic [1:0]        in_en;
  logic [1:0]        out_en;
  logic [AW-1:0]     addr_q   [2];
  logic [DW-1:0]     din_q    [2];
  logic [1:0]        we_q;
  logic [1:0]        re_q;
  logic [1:0]        go_q;
  logic [1:0]        we_eff;
  logic [1:0]        rd_eff;
  logic [1:0]        mix_hit;
  logic [DW-1:0]     mem_rd   [2];
  logic [DW-1:0]     sel      [2];
  logic [1:0]        und;
  logic [DW-1:0]     lat_q    [2];
  logic [1:0]        lat_und_q;
  logic [DW-1:0]     oreg_q   [2];
  logic [1:0]        oreg_und_q;
  logic [DW-1:0]     q_arr    [2];
  logic [1:0]        q_und;
  logic [`CTRL_W-1:0] rd_gate;
  logic [`STAT_W-1:0] stat_set;
  logic [`AXI_DATA_W-1:0] cfg_word;

  // gather the two ports into arrays
  assign addr_in[0] = addr_a;
  assign addr_in[1] = addr_b;
  assign din_in[0]  = din_a;
  assign din_in[1]  = din_b;
  assign we_in      = {we_b, we_a};
  assign re_in      = {re_b, re_a};
  assign q_a        = q_arr[0];
  assign q_b        = q_arr[1];
  assign q_undef_a  = q_und[0];
  assign q_undef_b  = q_und[1];

  // map the enables onto input and output register groups
  assign in_en[0]  = ce_a;
  assign in_en[1]  = (IS_RW) ? ce_b : ce_a;
  assign out_en[0] = (IS_IO) ? ce_b : ce_a;
  assign out_en[1] = (IS_IO || IS_RW) ? ce_b : ce_a;

  // per-port datapath
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam int O = 1 - p;

    // input registers carry no reset; only the go flag does
    always_ff @(posedge aclk)
    begin
      if (in_en[p])
      begin
        addr_q[p] <= addr_in[p];
        din_q[p]  <= din_in[p];
        we_q[p]   <= we_in[p];
        re_q[p]   <= re_in[p];
      end
    end

    // registered copy of the enable, high each cycle after the input group took a new operation
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        go_q[p] <= 1'b0;
      else
        go_q[p] <= in_en[p];
    end

    // split mode: port a only writes, port b only reads
    assign we_eff[p] = go_q[p] && we_q[p] && !(IS_RW && p == 1);
    assign rd_eff[p] = go_q[p] && re_q[p] && !rd_gate[p]
                       && !(IS_RW && p == 0);
    assign mix_hit[p] = we_eff[O] && addr_q[O] == addr_q[p];

    // read-during-write output choice
    always_comb
    begin
      sel[p] = mem_rd[p];
      und[p] = 1'b0;
      if (we_eff[p])
      begin
        unique case (SP_MODE)
          RDW_NEW: sel[p] = din_q[p];
          RDW_OLD: sel[p] = mem_rd[p];
          RDW_DC:  und[p] = 1'b1;
        endcase
      end
      else if (mix_hit[p])
      begin
        if (IS_RW)
          und[p] = 1'b1;
        else
        begin
          unique case (MIXED_RDW)
            RDW_NEW: sel[p] = din_q[O];
            RDW_OLD: sel[p] = mem_rd[p];
            RDW_DC:  und[p] = 1'b1;
          endcase
        end
      end
    end

    // output latch: loaded on an effective read, cleared by out_clr or reset
    always_ff @(posedge aclk)
    begin
      if (!aresetn || out_clr)
      begin
        lat_q[p]     <= '0;
        lat_und_q[p] <= 1'b0;
      end
      else if (rd_eff[p])
      begin
        lat_q[p]     <= sel[p];
        lat_und_q[p] <= und[p];
      end
    end

    // optional output register on the output enable
    always_ff @(posedge aclk)
    begin
      if (!aresetn || out_clr)
      begin
        oreg_q[p]     <= '0;
        oreg_und_q[p] <= 1'b0;
      end
      else if (out_en[p])
      begin
        oreg_q[p]     <= lat_q[p];
        oreg_und_q[p] <= lat_und_q[p];
      end
    end

    // logic-array ram without output register reads the cells directly
    assign q_arr[p] = OUT_REG ? oreg_q[p] :
                      (KIND == KIND_LOGIC) ? mem_rd[p] :
                      lat_q[p];
    assign q_und[p] = OUT_REG ? oreg_und_q[p] :
                      (KIND == KIND_LOGIC) ? 1'b0 : lat_und_q[p];
  end

  // storage cells
  ram_store #(
    .AW        (AW),
    .DW        (DW),
    .INIT_WORD (INIT_WORD)
  ) u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we_a    (we_eff[0]),
    .waddr_a (addr_q[0]),
    .wdata_a (din_q[0]),
    .we_b    (we_eff[1]),
    .waddr_b (addr_q[1]),
    .wdata_b (din_q[1]),
    .raddr_a (addr_q[0]),
    .raddr_b (addr_q[1]),
    .rdata_a (mem_rd[0]),
    .rdata_b (mem_rd[1])
  );

  // status events: dual-write clash and undefined output produced
  assign stat_set[`STAT_WCONF] = &we_eff && addr_q[0] == addr_q[1];
  assign stat_set[`STAT_UNDEF] = |(rd_eff & und);
  assign cfg_word = {{`CFG_PAD_W{1'b0}}, OUT_REG, 2'(KIND),
                     2'(MIXED_RDW), 2'(SP_MODE), 2'(CLK_MODE)};

  // register bus slave
  axil_regs u_regs (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .stat_set (stat_set),
    .cfg_word (cfg_word),
    .ctrl_q   (rd_gate)
  );

  // checks on the datapath
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence same_rd_wr_s;
    rd_eff[0] && we_eff[0] && !out_clr;
  endsequence

  sequence mixed_rd_wr_s;
    rd_eff[1] && !we_eff[1] && mix_hit[1] && !out_clr;
  endsequence

  sequence lat_then_out_s;
    rd_eff[0] && !out_clr ##1 out_en[0] && !out_clr;
  endsequence

  hold_inputs_a: assert property (
    !in_en[0] |=> $stable(addr_q[0]) && $stable(din_q[0]))
    else $error("input group changed without its enable");

  clear_output_a: assert property (
    out_clr |=> lat_q[0] == '0 && lat_und_q[1] == 1'b0
               && oreg_q[1] == '0)
    else $error("output clear left data in the output stage");

  same_new_a: assert property (
    same_rd_wr_s and (SP_MODE == RDW_NEW) |=> lat_q[0] == $past(din_q[0]))
    else $error("new data not shown on same-port write");

  same_old_a: assert property (
    same_rd_wr_s and (SP_MODE == RDW_OLD) |=> lat_q[0] == $past(mem_rd[0]))
    else $error("old data not shown on same-port write");

  mixed_old_a: assert property (
    mixed_rd_wr_s and (!IS_RW && MIXED_RDW == RDW_OLD)
    |=> lat_q[1] == $past(mem_rd[1]) && !lat_und_q[1])
    else $error("mixed-port old data wrong");

  split_undef_a: assert property (
    mixed_rd_wr_s and (IS_RW) |=> lat_und_q[1])
    else $error("split-clock collision not flagged undefined");

  powerup_zero_a: assert property (
    $past(!aresetn) && !(KIND == KIND_LOGIC && !OUT_REG)
    |-> q_a == '0 && q_b == '0)
    else $error("outputs not cleared after reset");

  out_delay_a: assert property (
    lat_then_out_s |=> oreg_q[0] == $past(lat_q[0]) && (!OUT_REG
    || q_a == $past(lat_q[0])))
    else $error("output register did not add one stage");

endmodule
`default_nettype wire

// ===== dv/ram_user_model.sv
// user-side logic model driving both memory ports
`timescale 1ns/10ps
`default_nettype none

module ram_user_model #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input  wire logic          aclk,
  output logic               ce_a,
  output logic               we_a,
  output logic               re_a,
  output logic      [AW-1:0] addr_a,
  output logic      [DW-1:0] din_a,
  output logic               ce_b,
  output logic               we_b,
  output logic               re_b,
  output logic      [AW-1:0] addr_b,
  output logic      [DW-1:0] din_b
);
  // idle port state at time zero
  initial
  begin
    {ce_a, we_a, re_a, ce_b, we_b, re_b} = '0;
    {addr_a, addr_b, din_a, din_b} = '0;
  end

  // one operation cycle on both ports, then idle with reads off
  task automatic op(input bit en, input bit wa, input bit ra,
                    input logic [AW-1:0] aa, input logic [DW-1:0] da,
                    input bit wb, input bit rb,
                    input logic [AW-1:0] ab, input logic [DW-1:0] db,
                    input bit clash);
    @(posedge aclk);
    ce_a   <= en;
    ce_b   <= en;
    we_a   <= wa;
    re_a   <= ra;
    addr_a <= aa;
    din_a  <= da;
    re_b   <= rb;
    addr_b <= ab;
    din_b  <= db;
    we_b   <= wb && !(wa && aa == ab && !clash);
    @(posedge aclk);
    {we_a, we_b, re_a, re_b} <= '0;
    // enables stay up so an output register can take the result
    repeat (2) @(posedge aclk);
    {ce_a, ce_b} <= '0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ===== dv/dp_ram_top_test.sv
// self-checking bench for the dual-port ram block
`timescale 1ns/10ps
`default_nettype none
`include "ram_params.svh"

module dp_ram_top_test;
  import ram_pkg::*;
  logic        aclk, aresetn, out_clr;
  logic        ce_a, we_a, re_a, ce_b, we_b, re_b;
  logic [8:0]  addr_a, addr_b;
  logic [15:0] din_a, din_b, q_a, q_b, lf, v;
  logic        q_undef_a, q_undef_b;
  logic [15:0] q_a2, q_b2;
  logic        q_undef_b2;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] ref_mem [512];
  int          n_fail, n_compared;

  dp_ram_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce_a(ce_a),
    .we_a(we_a), .re_a(re_a), .addr_a(addr_a), .din_a(din_a), .q_a(q_a),
    .q_undef_a(q_undef_a), .ce_b(ce_b), .we_b(we_b), .re_b(re_b),
    .addr_b(addr_b), .din_b(din_b), .q_b(q_b), .q_undef_b(q_undef_b),
    .out_clr(out_clr), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // second build: old same-port data, don't-care mixed, output register
  dp_ram_top #(.SAME_RDW(RDW_OLD), .MIXED_RDW(RDW_DC), .KIND(KIND_LARGE),
    .OUT_REG(1'b1)) i_dut_oreg (.aclk(aclk), .aresetn(aresetn),
    .ce_a(ce_a), .we_a(we_a), .re_a(re_a), .addr_a(addr_a),
    .din_a(din_a), .q_a(q_a2), .q_undef_a(), .ce_b(ce_b), .we_b(we_b),
    .re_b(re_b), .addr_b(addr_b), .din_b(din_b), .q_b(q_b2),
    .q_undef_b(q_undef_b2), .out_clr(out_clr), .awaddr(awaddr),
    .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(),
    .rvalid(), .rready(rready));

  ram_user_model i_user (.aclk(aclk), .ce_a(ce_a), .we_a(we_a),
    .re_a(re_a), .addr_a(addr_a), .din_a(din_a), .ce_b(ce_b),
    .we_b(we_b), .re_b(re_b), .addr_b(addr_b), .din_b(din_b));

  // next pseudo-random word
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // compare a read data word
  task automatic chk_q(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // compare a bus word or response
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // bus write: values seen at negedge are those sampled next edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit ta, tw, tb;
    tb = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  // bus read
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit ta, tr;
    tr = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  // clock generation
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    final_report();
  end

  // main sequence
  initial
  begin
    {aresetn, out_clr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    n_fail = 0;
    n_compared = 0;
    lf = 16'h004d;
    foreach (ref_mem[i]) ref_mem[i] = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk_q(q_a, 16'h0000);
    chk_q(q_b, 16'h0000);
    chk_q(q_a2, 16'h0000);
    axi_rd(`REG_CTRL, rd, rs);
    chk_reg(rd, 32'h0);
    axi_rd(`REG_STATUS, rd, rs);
    chk_reg(rd, 32'h0);
    axi_rd(`REG_CONFIG, rd, rs);
    chk_reg(rd, 32'h0000_0010);
    axi_rd(4'hc, rd, rs);
    chk_reg(32'(rs), 32'(`RESP_SLVERR));
    // same port write then read-during-write with new data
    i_user.op(1, 1, 0, 9'h005, 16'h1111, 0, 0, 9'h0, 16'h0, 0);
    i_user.op(1, 1, 1, 9'h005, 16'h2222, 0, 0, 9'h0, 16'h0, 0);
    #1 chk_q(q_a, 16'h2222);
    chk_q(16'(q_undef_a), 16'h0000);
    chk_q(q_a2, 16'h1111);
    // mixed port: b reads while a writes the same word
    i_user.op(1, 1, 0, 9'h005, 16'h3333, 0, 1, 9'h005, 16'h0, 0);
    #1 chk_q(q_b, 16'h2222);
    chk_q(16'(q_undef_b), 16'h0000);
    chk_q(16'(q_undef_b2), 16'h0001);
    i_user.op(1, 0, 0, 9'h0, 16'h0, 0, 1, 9'h005, 16'h0, 0);
    #1 chk_q(q_b, 16'h3333);
    // enable low: nothing is written
    i_user.op(0, 1, 0, 9'h005, 16'h4444, 0, 0, 9'h0, 16'h0, 0);
    i_user.op(1, 0, 1, 9'h005, 16'h0, 0, 0, 9'h0, 16'h0, 0);
    #1 chk_q(q_a, 16'h3333);
    // output clear leaves the cells alone
    @(posedge aclk);
    out_clr <= 1'b1;
    @(posedge aclk);
    out_clr <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 chk_q(q_a, 16'h0000);
    chk_q(q_b, 16'h0000);
    chk_q(q_a2, 16'h0000);
    i_user.op(1, 0, 1, 9'h005, 16'h0, 0, 0, 9'h0, 16'h0, 0);
    #1 chk_q(q_a, 16'h3333);
    // read gate on port a holds its output
    axi_wr(`REG_CTRL, 32'h1, rs);
    chk_reg(32'(rs), 32'(`RESP_OKAY));
    axi_rd(`REG_CTRL, rd, rs);
    chk_reg(rd, 32'h1);
    i_user.op(1, 0, 0, 9'h0, 16'h0, 1, 0, 9'h006, 16'h5555, 0);
    i_user.op(1, 0, 1, 9'h006, 16'h0, 0, 0, 9'h0, 16'h0, 0);
    #1 chk_q(q_a, 16'h3333);
    axi_wr(`REG_CTRL, 32'h0, rs);
    // deliberate dual write flags the clash
    i_user.op(1, 1, 0, 9'h007, 16'h6666, 1, 0, 9'h007, 16'h7777, 1);
    axi_rd(`REG_STATUS, rd, rs);
    chk_reg(rd, 32'h1);
    axi_wr(`REG_STATUS, 32'h1, rs);
    axi_rd(`REG_STATUS, rd, rs);
    chk_reg(rd, 32'h0);
    ref_mem[5] = 16'h3333;
    ref_mem[6] = 16'h5555;
    ref_mem[7] = 16'h6666;
    // random writes on a, read back on b
    repeat (24)
    begin
      lf = lfsr(lf);
      v = lfsr(lf);
      i_user.op(1, 1, 0, lf[8:0], v, 0, 0, 9'h0, 16'h0, 0);
      ref_mem[lf[8:0]] = v;
      lf = lfsr(v);
      i_user.op(1, 0, 0, 9'h0, 16'h0, 0, 1, lf[8:0], 16'h0, 0);
      #1 chk_q(q_b, ref_mem[lf[8:0]]);
      chk_q(q_b2, ref_mem[lf[8:0]]);
    end
    final_report();
  end
endmodule
`default_nettype wire
